// ### test_jump_event_wait_unit.sv
// Test-and-jump branch resolution and event-wait execution with counter events and AXI4-Lite registers
//
// Functional notes
// - Jump-if-all-ones branches when tested register equals all ones; negated form otherwise.
// - All-ones pair decodes from opcode 1011101, effect 00I and 01I.
// - Jump-if-negative branches when bit 31 set; negated form when clear.
// - Sign pair decodes from opcode 1011101, effect 10I and 11I.
// - Overflow jump branches when bit 31 differs from the carry flag.
// - Overflow jump decodes from opcode 1011110, effect 00I; flags untouched.
// - Zero jump branches when register is zero; negated form when nonzero.
// - Zero pair decodes from opcode 1011100, effect 10I and 11I.
// - Without immediate flag the target is an absolute 20-bit register address.
// - Immediate target is a 9-bit signed instruction offset, -256 to +255.
// - With a source extension prefix the offset becomes 20-bit signed.
// - Relative offset is added to the address of the following instruction.
// - Local execution adds offset as-is; shared memory execution scales it by four.
// - Wait ends at once if flag set, else on event; flag cleared unless re-set.
// - Requested flag writes are one on timeout, zero when the event came first.
// - While waiting the pipeline stalls fully; no instruction executes, though AXI accesses are still served.
// - Attention flag sets when another core requests attention of this core.
// - Attention flag clears at core start, on event_clear bit 0 and on attention wait.
// - Attention wait decodes from 1101011, effect CZ0, dest 000011110, src 000100100.
// - Counter flag sets when counter passes compare: MSB of difference becomes zero.
// - Counter flag clears on its event_clear bit or a matching wait; compare writes and jumps leave it.
// - Counter waits decode from 1101011, src 000100100, dest 000010001..000010011.
`timescale 1ns/1ps
module test_jump_event_wait_unit #(
    parameter int ADDR_W = 6
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic instr_valid,
    input wire logic [31:0] instr_word,
    input wire logic [31:0] dest_value,
    input wire logic [31:0] src_value,
    input wire logic [tjw_pkg::PC_W-1:0] pc_current,
    input wire logic hub_exec,
    input wire logic carry_in,
    input wire logic prefix_valid,
    input wire logic [31:0] prefix_value,
    input wire logic aug_valid,
    input wire logic [tjw_pkg::AUG_W-1:0] aug_value,
    input wire logic attention_request,
    input wire logic core_start,
    input wire logic [tjw_pkg::NUM_EV-1:0] event_clear,
    output logic instr_done,
    output logic branch_taken,
    output logic [tjw_pkg::PC_W-1:0] pc_next,
    output logic stall,
    output logic flag_write_c,
    output logic flag_write_z,
    output logic flag_value,
    output logic [tjw_pkg::NUM_EV-1:0] event_flags,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef struct packed {
        tjw_pkg::exec_state_t mode;
        logic [1:0] wait_sel;
        logic wait_wc;
        logic wait_wz;
        logic timeout_armed;
        logic [31:0] deadline;
        logic prefix_armed;
        logic [31:0] prefix_val;
        logic aug_armed;
        logic [tjw_pkg::AUG_W-1:0] aug_val;
        logic [31:0] counter;
        logic [tjw_pkg::NUM_CT-1:0][31:0] compare;
        logic [tjw_pkg::NUM_CT-1:0] ct_msb_prev;
        logic [tjw_pkg::NUM_EV-1:0] ev_flag;
        logic done;
        logic taken;
        logic [tjw_pkg::PC_W-1:0] pc_out;
        logic stall;
        logic c_wr;
        logic z_wr;
        logic fval;
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic awrdy, wrdy, arrdy;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // Counter event sensors, one per compare register
    logic [tjw_pkg::NUM_CT-1:0] ct_msb;
    logic [tjw_pkg::NUM_CT-1:0] ct_pass;
    genvar gi;
    generate
        for (gi = 0; gi < tjw_pkg::NUM_CT; gi++) begin : g_ct
            logic [31:0] diff;
            assign diff = state_reg.counter - state_reg.compare[gi];
            assign ct_msb[gi] = diff[31];
            assign ct_pass[gi] = state_reg.ct_msb_prev[gi] & ~diff[31];
        end
    endgenerate

    // Instruction fields
    logic [6:0] opc;
    logic [2:0] fx;
    logic [8:0] dfield;
    logic [8:0] sfield;
    assign opc = instr_word[tjw_pkg::OPC_LSB +: 7];
    assign fx = instr_word[tjw_pkg::FX_LSB +: 3];
    assign dfield = instr_word[tjw_pkg::DST_LSB +: 9];
    assign sfield = instr_word[tjw_pkg::SRC_LSB +: 9];

    logic is_ones_sign;
    logic is_ovf;
    logic is_zero;
    logic is_jump;
    logic jump_cond;
    logic is_wait;
    logic [1:0] wsel;
    logic [tjw_pkg::PC_W-1:0] offset;
    logic [tjw_pkg::PC_W-1:0] seq_pc;
    logic [tjw_pkg::PC_W-1:0] target;
    logic [31:0] tmo_diff;
    logic run_accept;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0] status_word;

    assign is_ones_sign = (opc == tjw_pkg::OPC_TJ_ONES_SIGN);
    assign is_ovf = (opc == tjw_pkg::OPC_TJ_OVF) && (fx[2:1] == tjw_pkg::FX_OVERFLOW);
    assign is_zero = (opc == tjw_pkg::OPC_TJ_ZERO)
        && ((fx[2:1] == tjw_pkg::FX_ZERO) || (fx[2:1] == tjw_pkg::FX_NONZERO));
    assign is_jump = is_ones_sign | is_ovf | is_zero;
    assign run_accept = instr_valid && (state_reg.mode == tjw_pkg::ST_RUN);

    always_comb begin
        jump_cond = 1'b0;
        if (is_ones_sign) begin
            case (fx[2:1])
                tjw_pkg::FX_ALL_ONES: jump_cond = (dest_value == 32'hffff_ffff);
                tjw_pkg::FX_NOT_ALL_ONES: jump_cond = (dest_value != 32'hffff_ffff);
                tjw_pkg::FX_NEGATIVE: jump_cond = dest_value[tjw_pkg::SIGN_BIT];
                default: jump_cond = ~dest_value[tjw_pkg::SIGN_BIT];
            endcase
        end else if (is_ovf) begin
            jump_cond = dest_value[tjw_pkg::SIGN_BIT] != carry_in;
        end else if (is_zero) begin
            jump_cond = (fx[2:1] == tjw_pkg::FX_ZERO) ? (dest_value == 32'h0)
                                                      : (dest_value != 32'h0);
        end
    end

    always_comb begin
        is_wait = (opc == tjw_pkg::OPC_EVENT) && (sfield == tjw_pkg::SRC_WAIT) && !fx[0];
        wsel = 2'h0;
        case (dfield)
            tjw_pkg::DST_WAIT_ATN: wsel = 2'h0;
            tjw_pkg::DST_WAIT_CT1: wsel = 2'h1;
            tjw_pkg::DST_WAIT_CT2: wsel = 2'h2;
            tjw_pkg::DST_WAIT_CT3: wsel = 2'h3;
            default: is_wait = 1'b0;
        endcase
    end

    // Branch target: absolute from register, or relative to the following instruction
    assign offset = state_reg.aug_armed ? {state_reg.aug_val, sfield}
                                        : {{(tjw_pkg::PC_W-9){sfield[8]}}, sfield};
    assign seq_pc = pc_current + (hub_exec ? 20'h00004 : 20'h00001);
    assign target = fx[0] ? (seq_pc + (hub_exec ? {offset[17:0], 2'b00} : offset))
                          : src_value[tjw_pkg::PC_W-1:0];
    assign tmo_diff = state_reg.counter - state_reg.deadline;

    assign rd_addr = s_axi_araddr;
    assign status_word = {{(32-tjw_pkg::STATUS_WAIT_BIT-1){1'b0}},
                          state_reg.mode == tjw_pkg::ST_WAIT, state_reg.ev_flag};

    always_comb begin
        logic [tjw_pkg::NUM_EV-1:0] set_v;
        logic [tjw_pkg::NUM_EV-1:0] clr_v;
        logic [1:0] wr_idx;
        set_v = '0;
        clr_v = '0;
        wr_idx = 2'h0;
        state_next = state_reg;
        state_next.done = 1'b0;
        state_next.c_wr = 1'b0;
        state_next.z_wr = 1'b0;
        state_next.counter = state_reg.counter + 32'h1;
        state_next.ct_msb_prev = ct_msb;
        set_v[tjw_pkg::EV_ATN] = attention_request;
        set_v[tjw_pkg::NUM_EV-1:tjw_pkg::EV_CT1] = ct_pass;
        clr_v = event_clear;
        clr_v[tjw_pkg::EV_ATN] = event_clear[tjw_pkg::EV_ATN] | core_start;
        if (prefix_valid) begin
            state_next.prefix_armed = 1'b1;
            state_next.prefix_val = prefix_value;
        end
        if (aug_valid) begin
            state_next.aug_armed = 1'b1;
            state_next.aug_val = aug_value;
        end
        if (state_reg.mode == tjw_pkg::ST_RUN) begin
            if (run_accept) begin
                state_next.prefix_armed = 1'b0;
                state_next.aug_armed = 1'b0;
                if (is_jump) begin
                    state_next.done = 1'b1;
                    state_next.taken = jump_cond;
                    state_next.pc_out = jump_cond ? target : seq_pc;
                end else if (is_wait) begin
                    state_next.wait_sel = wsel;
                    state_next.wait_wc = fx[2];
                    state_next.wait_wz = fx[1];
                    state_next.taken = 1'b0;
                    state_next.pc_out = seq_pc;
                    if (state_reg.ev_flag[wsel]) begin
                        state_next.done = 1'b1;
                        clr_v[wsel] = 1'b1;
                        state_next.c_wr = fx[2];
                        state_next.z_wr = fx[1];
                        state_next.fval = 1'b0;
                    end else begin
                        state_next.mode = tjw_pkg::ST_WAIT;
                        state_next.timeout_armed = state_reg.prefix_armed;
                        state_next.deadline = state_reg.prefix_val;
                    end
                end
            end
        end else begin
            if (state_reg.ev_flag[state_reg.wait_sel]) begin
                state_next.mode = tjw_pkg::ST_RUN;
                state_next.done = 1'b1;
                clr_v[state_reg.wait_sel] = 1'b1;
                state_next.c_wr = state_reg.wait_wc;
                state_next.z_wr = state_reg.wait_wz;
                state_next.fval = 1'b0;
            end else if (state_reg.timeout_armed && !tmo_diff[31]) begin
                state_next.mode = tjw_pkg::ST_RUN;
                state_next.done = 1'b1;
                state_next.c_wr = state_reg.wait_wc;
                state_next.z_wr = state_reg.wait_wz;
                state_next.fval = 1'b1;
            end
        end
        // Set wins over a clear in the same cycle
        state_next.ev_flag = (state_reg.ev_flag & ~clr_v) | set_v;
        state_next.stall = (state_next.mode == tjw_pkg::ST_WAIT);

        // AXI4-Lite write: address and data taken in either order
        if (s_axi_awvalid && !state_reg.aw_got && !state_reg.bvalid) begin
            state_next.aw_got = 1'b1;
            state_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !state_reg.w_got && !state_reg.bvalid) begin
            state_next.w_got = 1'b1;
            state_next.w_data = s_axi_wdata;
            state_next.w_strb = s_axi_wstrb;
        end
        if (state_reg.aw_got && state_reg.w_got) begin
            state_next.aw_got = 1'b0;
            state_next.w_got = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = tjw_pkg::RESP_OKAY;
            wr_idx = state_reg.aw_addr[3:2];
            case (state_reg.aw_addr)
                tjw_pkg::ADDR_COMPARE1, tjw_pkg::ADDR_COMPARE2, tjw_pkg::ADDR_COMPARE3: begin
                    for (int b = 0; b < 4; b++) begin
                        if (state_reg.w_strb[b]) begin
                            state_next.compare[wr_idx][8*b +: 8] = state_reg.w_data[8*b +: 8];
                        end
                    end
                end
                tjw_pkg::ADDR_COUNTER, tjw_pkg::ADDR_STATUS: ;
                default: state_next.bresp = tjw_pkg::RESP_SLVERR;
            endcase
        end
        if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
        end
        // AXI4-Lite read
        if (state_reg.rvalid) begin
            if (s_axi_rready) begin
                state_next.rvalid = 1'b0;
            end
        end else if (s_axi_arvalid) begin
            state_next.rvalid = 1'b1;
            state_next.rresp = tjw_pkg::RESP_OKAY;
            case (rd_addr)
                tjw_pkg::ADDR_COMPARE1: state_next.rdata = state_reg.compare[0];
                tjw_pkg::ADDR_COMPARE2: state_next.rdata = state_reg.compare[1];
                tjw_pkg::ADDR_COMPARE3: state_next.rdata = state_reg.compare[2];
                tjw_pkg::ADDR_COUNTER: state_next.rdata = state_reg.counter;
                tjw_pkg::ADDR_STATUS: state_next.rdata = status_word;
                default: begin
                    state_next.rdata = 32'h0;
                    state_next.rresp = tjw_pkg::RESP_SLVERR;
                end
            endcase
        end
        state_next.awrdy = !state_next.aw_got && !state_next.bvalid;
        state_next.wrdy = !state_next.w_got && !state_next.bvalid;
        state_next.arrdy = !state_next.rvalid;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= '0;
            state_reg.mode <= tjw_pkg::ST_RUN;
            state_reg.counter <= tjw_pkg::RESET_COUNTER;
            state_reg.compare <= {tjw_pkg::NUM_CT{tjw_pkg::RESET_COMPARE}};
            state_reg.awrdy <= 1'b1;
            state_reg.wrdy <= 1'b1;
            state_reg.arrdy <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign instr_done = state_reg.done;
    assign branch_taken = state_reg.taken;
    assign pc_next = state_reg.pc_out;
    assign stall = state_reg.stall;
    assign flag_write_c = state_reg.c_wr;
    assign flag_write_z = state_reg.z_wr;
    assign flag_value = state_reg.fval;
    assign event_flags = state_reg.ev_flag;
    assign s_axi_awready = state_reg.awrdy;
    assign s_axi_wready = state_reg.wrdy;
    assign s_axi_bvalid = state_reg.bvalid;
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_arready = state_reg.arrdy;
    assign s_axi_rvalid = state_reg.rvalid;
    assign s_axi_rdata = state_reg.rdata;
    assign s_axi_rresp = state_reg.rresp;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    function automatic logic set_hit(logic [1:0] idx);
        set_hit = (idx == 2'h0) ? attention_request : ct_pass[idx-2'h1];
    endfunction

    sequence s_jump_issue(logic [1:0] code);
        run_accept && is_ones_sign && fx[2:1] == code;
    endsequence
    sequence s_wait_enter;
        run_accept && is_wait && !state_reg.ev_flag[wsel] && !set_hit(wsel)
            && !state_reg.prefix_armed;
    endsequence

    a_all_ones_jump: assert property (s_jump_issue(tjw_pkg::FX_ALL_ONES)
        ##0 dest_value == '1 |=> branch_taken && instr_done) else $error("all-ones jump missed");
    a_not_ones_jump: assert property (s_jump_issue(tjw_pkg::FX_NOT_ALL_ONES)
        ##0 dest_value == '1 |=> !branch_taken) else $error("not-all-ones jump taken wrongly");
    a_sign_jump: assert property (s_jump_issue(tjw_pkg::FX_NEGATIVE)
        |=> branch_taken == $past(dest_value[31])) else $error("negative jump wrong");
    a_ovf_jump: assert property (run_accept && is_ovf
        |=> branch_taken == ($past(dest_value[31]) != $past(carry_in)) && !flag_write_c
        && !flag_write_z) else $error("overflow jump wrong");
    a_zero_jump: assert property (run_accept && is_zero && fx[2:1] == tjw_pkg::FX_ZERO
        |=> branch_taken == ($past(dest_value) == 32'h0)) else $error("zero jump wrong");
    a_rel_target: assert property (run_accept && is_jump && jump_cond && fx[0]
        && !hub_exec && !state_reg.aug_armed |=> pc_next == $past(pc_current) + 20'h1
        + {{11{$past(sfield[8])}}, $past(sfield)}) else $error("relative target wrong");
    a_false_seq: assert property (run_accept && is_jump && !jump_cond |=> !branch_taken
        && pc_next == $past(seq_pc) && !flag_write_c) else $error("false jump not sequential");
    a_wait_stalls: assert property (s_wait_enter
        |=> stall ##0 (stall && !instr_done) [*2]) else $error("wait did not stall");
    a_ready_wait: assert property (run_accept && is_wait && state_reg.ev_flag[wsel]
        && !set_hit(wsel) |=> instr_done && !stall && !event_flags[$past(wsel)])
        else $error("ready wait did not finish");
    a_timeout_flags: assert property (stall && state_reg.timeout_armed
        && !state_reg.ev_flag[state_reg.wait_sel] && !tmo_diff[31]
        |=> !stall && instr_done && flag_value) else $error("timeout not reported");
    a_atn_set: assert property (attention_request |=> event_flags[tjw_pkg::EV_ATN])
        else $error("attention request lost");
endmodule : test_jump_event_wait_unit

// ### tjw_pkg.sv
// Package: encodings, field positions, register map and reset values of the test-jump/event-wait unit
package tjw_pkg;
    localparam int DATA_W = 32;
    localparam int PC_W = 20;
    localparam int AUG_W = 11;
    localparam int NUM_CT = 3;
    localparam int NUM_EV = 4;
    // Instruction word fields
    localparam int OPC_LSB = 21;
    localparam int FX_LSB = 18;
    localparam int DST_LSB = 9;
    localparam int SRC_LSB = 0;
    localparam int SIGN_BIT = 31;
    // Opcodes and effect codes
    localparam logic [6:0] OPC_TJ_ONES_SIGN = 7'h5d;
    localparam logic [6:0] OPC_TJ_OVF = 7'h5e;
    localparam logic [6:0] OPC_TJ_ZERO = 7'h5c;
    localparam logic [6:0] OPC_EVENT = 7'h6b;
    localparam logic [1:0] FX_ALL_ONES = 2'h0;
    localparam logic [1:0] FX_NOT_ALL_ONES = 2'h1;
    localparam logic [1:0] FX_NEGATIVE = 2'h2;
    localparam logic [1:0] FX_NON_NEGATIVE = 2'h3;
    localparam logic [1:0] FX_OVERFLOW = 2'h0;
    localparam logic [1:0] FX_ZERO = 2'h2;
    localparam logic [1:0] FX_NONZERO = 2'h3;
    localparam logic [8:0] SRC_WAIT = 9'h024;
    localparam logic [8:0] DST_WAIT_ATN = 9'h01e;
    localparam logic [8:0] DST_WAIT_CT1 = 9'h011;
    localparam logic [8:0] DST_WAIT_CT2 = 9'h012;
    localparam logic [8:0] DST_WAIT_CT3 = 9'h013;
    // Event flag positions
    localparam int EV_ATN = 0;
    localparam int EV_CT1 = 1;
    // Register map (byte addresses) and status fields
    localparam logic [5:0] ADDR_COMPARE1 = 6'h00;
    localparam logic [5:0] ADDR_COMPARE2 = 6'h04;
    localparam logic [5:0] ADDR_COMPARE3 = 6'h08;
    localparam logic [5:0] ADDR_COUNTER = 6'h0c;
    localparam logic [5:0] ADDR_STATUS = 6'h10;
    localparam int STATUS_WAIT_BIT = 4;
    localparam logic [31:0] RESET_COMPARE = 32'h0000_0000;
    localparam logic [31:0] RESET_COUNTER = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [0:0] {
        ST_RUN = 1'b0,
        ST_WAIT = 1'b1
    } exec_state_t;
endpackage : tjw_pkg

// ### atn_source_model.sv
// Partner model: another core that sends attention requests to this core
`timescale 1ns/1ps
module atn_source_model (
    input wire logic clk_sys,
    input wire logic fire,
    output logic attention_request
);
    initial attention_request = 1'b0;
    // One request cycle per command, launched just after a clock edge
    always @(posedge clk_sys) attention_request <= fire;
endmodule : atn_source_model

// ### test_jump_event_wait_unit_tb_top.sv
// Testbench: test-and-jump branches, event waits and register access
`timescale 1ns/1ps
module test_jump_event_wait_unit_tb_top;
    logic clk_sys, rst, instr_valid, hub_exec, carry_in, prefix_valid, aug_valid, core_start;
    logic fire, attention_request, instr_done, branch_taken, stall;
    logic flag_write_c, flag_write_z, flag_value;
    logic [31:0] instr_word, dest_value, src_value, prefix_value, s_axi_wdata, s_axi_rdata, cnt, rd;
    logic [19:0] pc_current, pc_next;
    logic [10:0] aug_value;
    logic [3:0] event_clear, event_flags, s_axi_wstrb;
    logic [5:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    int bad_count = 0, checks_done = 0, n, stall_seen;
    test_jump_event_wait_unit i_dut (.clk_sys, .rst, .instr_valid, .instr_word, .dest_value,
        .src_value, .pc_current, .hub_exec, .carry_in, .prefix_valid, .prefix_value, .aug_valid,
        .aug_value, .attention_request, .core_start, .event_clear, .instr_done, .branch_taken,
        .pc_next, .stall, .flag_write_c, .flag_write_z, .flag_value, .event_flags, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    atn_source_model i_atn (.clk_sys, .fire, .attention_request);
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    task automatic close_out;
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : close_out
    // Prefix pulses go out one cycle ahead of the instruction they qualify
    task automatic issue(input logic [31:0] w, d, s, input logic c, h, input logic [11:0] au,
            input logic [32:0] q);
        @(posedge clk_sys);
        {aug_valid, aug_value} <= au;
        {prefix_valid, prefix_value} <= q;
        carry_in <= c;
        hub_exec <= h;
        @(posedge clk_sys);
        {instr_word, dest_value, src_value, instr_valid} <= {w, d, s, 1'b1};
        @(posedge clk_sys);
        {instr_valid, aug_valid, prefix_valid} <= 3'h0;
        for (n = 0; n < 1000; n++) begin
            @(negedge clk_sys);
            if (stall === 1'b1) stall_seen++;
            if (instr_done === 1'b1) break;
        end
        chk("done", 1'b1, instr_done);
    endtask : issue
    task automatic jump(input logic [6:0] op, input logic [2:0] fx, input logic [31:0] d, s,
            input logic c, h, input logic [11:0] au, input logic tk, input logic [19:0] t);
        issue({4'h0, op, fx, 9'h001, s[8:0]}, d, s, c, h, au, 33'h0);
        chk("taken", tk, branch_taken);
        chk("pc_next", tk ? t : pc_current + (h ? 20'd4 : 20'd1), pc_next);
        chk("jump flag writes", 0, {flag_write_c, flag_write_z});
    endtask : jump
    task automatic ewait(input logic [8:0] dst, input logic [2:0] fx, input logic [32:0] q,
            input logic fv);
        issue({4'h0, 7'h6b, fx, dst, 9'h024}, 0, 0, 0, 0, 12'h0, q);
        chk("wait taken", 0, branch_taken);
        chk("flag value", fv, flag_value);
        chk("wait flag writes", fx[2:1], {flag_write_c, flag_write_z});
    endtask : ewait
    task automatic axw(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        forever begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        chk("bresp", 2'h0, s_axi_bresp);
        s_axi_bready <= 1'b0;
    endtask : axw
    task automatic axr(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        forever begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask : axr
    task automatic atn_pulse;
        @(posedge clk_sys);
        fire <= 1'b1;
        @(posedge clk_sys);
        fire <= 1'b0;
        repeat (3) @(negedge clk_sys);
        chk("attention set", 1, event_flags[0]);
    endtask : atn_pulse
    initial begin
        repeat (5000) @(posedge clk_sys);
        bad_count++;
        close_out();
    end
    initial begin
        {rst, instr_valid, hub_exec, carry_in, prefix_valid, aug_valid, core_start, fire} = 8'h80;
        {instr_word, dest_value, src_value, prefix_value, aug_value, event_clear} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        pc_current = 20'h10000;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        jump(7'h5d, 3'b001, '1, 32'h1f0, 0, 0, 0, 1, 20'h0fff1);
        jump(7'h5d, 3'b001, 32'hfffffffe, 32'h1f0, 0, 0, 0, 0, 0);
        jump(7'h5d, 3'b011, 32'hfffffffe, 32'h0ff, 0, 0, 0, 1, 20'h10100);
        jump(7'h5d, 3'b011, '1, 32'h1f0, 0, 0, 0, 0, 0);
        jump(7'h5d, 3'b101, 32'h80000000, 32'h1f0, 0, 0, 0, 1, 20'h0fff1);
        jump(7'h5d, 3'b101, 32'h7fffffff, 32'h1f0, 0, 0, 0, 0, 0);
        jump(7'h5d, 3'b111, 32'h7fffffff, 32'h1f0, 0, 0, 0, 1, 20'h0fff1);
        jump(7'h5e, 3'b001, 32'h80000000, 32'h1f0, 0, 0, 0, 1, 20'h0fff1);
        jump(7'h5e, 3'b001, 32'h80000000, 32'h1f0, 1, 0, 0, 0, 0);
        jump(7'h5c, 3'b101, 0, 32'h1f0, 0, 0, 0, 1, 20'h0fff1);
        jump(7'h5c, 3'b101, 1, 32'h1f0, 0, 0, 0, 0, 0);
        jump(7'h5c, 3'b111, 1, 32'h1f0, 0, 0, 0, 1, 20'h0fff1);
        jump(7'h5c, 3'b111, 0, 32'h1f0, 0, 1, 0, 0, 0);
        jump(7'h5c, 3'b100, 0, 32'hfff12345, 0, 0, 0, 1, 20'h12345);
        jump(7'h5c, 3'b101, 0, 32'h100, 0, 1, 0, 1, 20'h0fc04);
        jump(7'h5c, 3'b101, 0, 32'h000, 0, 0, 12'hc00, 1, 20'h90001);
        $display("jump tests finished");
        atn_pulse();
        ewait(9'h01e, 3'b110, 0, 0);
        chk("attention cleared", 0, event_flags[0]);
        fork
            begin
                repeat (8) @(posedge clk_sys);
                fire <= 1'b1;
                @(posedge clk_sys);
                fire <= 1'b0;
            end
        join_none
        stall_seen = 0;
        ewait(9'h01e, 3'b100, 0, 0);
        chk("stalled while waiting", 1, stall_seen > 4);
        atn_pulse();
        @(posedge clk_sys);
        core_start <= 1'b1;
        @(posedge clk_sys);
        core_start <= 1'b0;
        @(negedge clk_sys);
        chk("attention after start", 0, event_flags[0]);
        $display("attention tests finished");
        axr(6'h0c, cnt, rr);
        for (int k = 1; k <= 3; k++) begin
            axw(6'(4 * (k - 1)), cnt + 200 * k);
            ewait(9'h010 + 9'(k), 3'b110,
                (k == 1) ? {1'b1, cnt + 60} : 33'h0, k == 1);
        end
        chk("counter one flag", 1, event_flags[1]);
        @(posedge clk_sys);
        event_clear <= 4'h2;
        @(posedge clk_sys);
        event_clear <= 4'h0;
        @(negedge clk_sys);
        chk("counter one cleared", 0, event_flags[1]);
        $display("counter tests finished");
        axr(6'h08, rd, rr);
        chk("compare three", cnt + 600, rd);
        axr(6'h14, rd, rr);
        chk("unmapped resp", 2'h2, rr);
        $display("register tests finished");
        close_out();
    end
endmodule : test_jump_event_wait_unit_tb_top
